/* File: common/pwmc_defines.svh */
// register offsets, field positions, reset values and timing counts of the pwm channel
`ifndef PWMC_DEFINES_SVH
`define PWMC_DEFINES_SVH
`define PWMC_ADDR_W        4
`define PWMC_OFS_CTRL      4'h0
`define PWMC_OFS_CLKSEL    4'h1
`define PWMC_OFS_FLAG      4'h2
`define PWMC_OFS_MASK      4'h3
`define PWMC_OFS_PERIOD    4'h4
`define PWMC_OFS_DUTY      4'h5
`define PWMC_OFS_PHASE     4'h6
`define PWMC_OFS_OFFSET    4'h7
`define PWMC_OFS_COUNT     4'h8
`define PWMC_OFS_MIRROR    4'h9
`define PWMC_CTRL_EN       7
`define PWMC_CTRL_OUT      5
`define PWMC_CTRL_INV      4
`define PWMC_CTRL_MODE_LO  2
`define PWMC_CTRL_RST      8'h00
`define PWMC_CLK_PS_LO     4
`define PWMC_CLK_CS_LO     0
`define PWMC_CLK_RST       8'h00
`define PWMC_FLAG_RST      8'h00
`define PWMC_FLAG_OFS      3
`define PWMC_FLAG_PH       2
`define PWMC_FLAG_DC       1
`define PWMC_FLAG_PR       0
`define PWMC_EVT_RST       16'h0000
`define PWMC_INSTR_DIV     4
`endif

/* File: common/pwmc_pkg.sv */
// types shared by the pwm channel files
`default_nettype none
package pwmc_pkg;
   typedef enum logic [1:0] {
      PWMC_CS_SYS  = 2'b00,
      PWMC_CS_HFO  = 2'b01,
      PWMC_CS_LFO  = 2'b10,
      PWMC_CS_RSVD = 2'b11
   } pwmc_csel_t;
   typedef enum logic [1:0] {
      PWMC_MODE_STD  = 2'b00,
      PWMC_MODE_SET  = 2'b01,
      PWMC_MODE_TOG  = 2'b10,
      PWMC_MODE_CTR  = 2'b11
   } pwmc_mode_t;
   typedef struct packed {
      logic [15:0] period;
      logic [15:0] duty;
      logic [15:0] phase;
      logic [15:0] offset;
   } pwmc_evt_t;
   typedef struct packed {
      logic ofs;
      logic ph;
      logic dc;
      logic pr;
   } pwmc_match_t;
endpackage : pwmc_pkg
`default_nettype wire

/* File: core/pwmc_tick.sv */
// clock-source pick and power-of-two prescaler giving counter ticks
`default_nettype none
`include "pwmc_defines.svh"
module pwmc_tick
   import pwmc_pkg::*;
#(
   parameter int PS_W = 3
) (
   // clock and reset
   input  wire logic             mclk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             ce_i,
   // control
   input  wire logic             run_i,
   input  wire pwmc_csel_t       csel_i,
   input  wire logic [PS_W-1:0]  ps_i,
   // oscillator pins
   input  wire logic             hfo_i,
   input  wire logic             lfo_i,
   // tick out
   output logic                  tick_o
);
   logic [1:0]   hfo_s_r, lfo_s_r, hfo_s_nxt, lfo_s_nxt;
   logic         hfo_d_r, lfo_d_r, hfo_d_nxt, lfo_d_nxt;
   logic [6:0]   pre_r, pre_nxt;
   logic         src_tick;
   logic [6:0]   pre_max;

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      hfo_s_nxt = {hfo_s_r[0], hfo_i};
      lfo_s_nxt = {lfo_s_r[0], lfo_i};
      hfo_d_nxt = hfo_s_r[1];
      lfo_d_nxt = lfo_s_r[1];
      pre_max   = 7'((8'h01 << ps_i) - 8'h01);
      unique case (csel_i)
         PWMC_CS_SYS: src_tick = 1'b1;
         PWMC_CS_HFO: src_tick = hfo_s_r[1] & ~hfo_d_r;
         PWMC_CS_LFO: src_tick = lfo_s_r[1] & ~lfo_d_r;
         default:     src_tick = 1'b0;
      endcase
      pre_nxt = pre_r;
      tick_o  = 1'b0;
      // divide by two to the ps
      if (!run_i) begin
         pre_nxt = 7'h00;
      end else if (src_tick) begin
         if (pre_r >= pre_max) begin
            pre_nxt = 7'h00;
            tick_o  = 1'b1;
         end else begin
            pre_nxt = 7'(pre_r + 7'h01);
         end
      end
      if (!ce_i) begin
         tick_o = 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         hfo_s_r <= 2'h0;
         lfo_s_r <= 2'h0;
         hfo_d_r <= 1'b0;
         lfo_d_r <= 1'b0;
         pre_r   <= 7'h00;
      end else if (ce_i) begin
         hfo_s_r <= hfo_s_nxt;
         lfo_s_r <= lfo_s_nxt;
         hfo_d_r <= hfo_d_nxt;
         lfo_d_r <= lfo_d_nxt;
         pre_r   <= pre_nxt;
      end
   end
endmodule : pwmc_tick
`default_nettype wire

/* File: core/pwmc_core.sv */
// one pwm channel: counter, event compare, output, flags and registers
// Operation
// - sixteen-bit counter gives pwm resolution
// - private counter from selected clock source
// - compare counter to event counts
// - own enable or shared mirror starts
// - output state bit readable
// - software may force output level outside standard mode
// - state bit resampled at system/4
// - open-drain drives low only
// - invert bit inverts output pin
// - inversion holds while channel disabled
// - flag register: offset phase duty period
// - flags hardware set, software read/write, a written one clears the flag
// - flags held clear while disabled
// - clock source select, code 11 reserved
// - prescaler divides by power of two
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`default_nettype none
`include "pwmc_defines.svh"
module pwmc_core
   import pwmc_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter int CH_ID = 0,
   parameter int NCH   = 4
) (
   // clock and reset
   input  wire logic                    mclk_i,
   input  wire logic                    sys_rst_i,
   input  wire logic                    ce_i,
   // register port
   input  wire logic [`PWMC_ADDR_W-1:0] addr_i,
   input  wire logic [15:0]             wdata_i,
   input  wire logic                    wr_i,
   input  wire logic                    rd_i,
   output logic      [15:0]             rdata_o,
   // oscillators
   input  wire logic                    hfo_i,
   input  wire logic                    lfo_i,
   // port pin config
   input  wire logic                    open_drain_bit_i,
   // pin and interrupt
   output logic                         pwm_o,
   output logic                         pwm_oe_n_o,
   output logic                         irq_o
);
   logic [7:0]       ctrl_r, ctrl_nxt;
   logic [7:0]       clk_r, clk_nxt;
   logic [3:0]       flag_r, flag_nxt;
   logic [3:0]       mask_r, mask_nxt;
   pwmc_evt_t        evt_r, evt_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic             wav_r, wav_nxt;
   logic             pin_r, pin_nxt;
   logic [1:0]       div_r, div_nxt;
   logic             out_s_r, out_s_nxt;
   logic [15:0]      rdata_r, rdata_nxt;
   logic             en;
   logic             tick;
   pwmc_match_t      hit;
   pwmc_mode_t       mode;
   logic             lvl;

   assign en   = ctrl_r[`PWMC_CTRL_EN];
   assign mode = pwmc_mode_t'(ctrl_r[`PWMC_CTRL_MODE_LO +: 2]);

   ////////////////////////////////////////////////////////////////////
   // private tick source
   pwmc_tick #(
      .PS_W (3)
   ) u_tick (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .ce_i      (ce_i),
      .run_i     (en),
      .csel_i    (pwmc_csel_t'(clk_r[`PWMC_CLK_CS_LO +: 2])),
      .ps_i      (clk_r[`PWMC_CLK_PS_LO +: 3]),
      .hfo_i     (hfo_i),
      .lfo_i     (lfo_i),
      .tick_o    (tick)
   );

   ////////////////////////////////////////////////////////////////////
   // counter and compares
   always_comb begin
      hit     = '0;
      cnt_nxt = cnt_r;
      if (en && tick) begin
         hit.pr  = (cnt_r == CNT_W'(evt_r.period));
         hit.dc  = (cnt_r == CNT_W'(evt_r.duty));
         hit.ph  = (cnt_r == CNT_W'(evt_r.phase));
         hit.ofs = (cnt_r == CNT_W'(evt_r.offset));
      end
      if (!en) begin
         cnt_nxt = '0;
      end else if (tick) begin
         cnt_nxt = hit.pr ? '0 : CNT_W'(cnt_r + 1'b1);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // waveform, pin and registers
   always_comb begin
      ctrl_nxt = ctrl_r;
      clk_nxt  = clk_r;
      mask_nxt = mask_r;
      evt_nxt  = evt_r;
      wav_nxt  = wav_r;
      flag_nxt = flag_r;
      if (wr_i) begin
         unique case (addr_i)
            `PWMC_OFS_CTRL:   ctrl_nxt = wdata_i[7:0];
            `PWMC_OFS_CLKSEL: clk_nxt  = wdata_i[7:0] & 8'h73;
            `PWMC_OFS_MASK:   mask_nxt = wdata_i[3:0];
            `PWMC_OFS_PERIOD: evt_nxt.period = wdata_i;
            `PWMC_OFS_DUTY:   evt_nxt.duty   = wdata_i;
            `PWMC_OFS_PHASE:  evt_nxt.phase  = wdata_i;
            `PWMC_OFS_OFFSET: evt_nxt.offset = wdata_i;
            `PWMC_OFS_MIRROR: ctrl_nxt[`PWMC_CTRL_EN] = wdata_i[CH_ID % NCH];
            default:          ctrl_nxt = ctrl_r;
         endcase
      end
      if (wr_i && addr_i == `PWMC_OFS_FLAG) begin
         flag_nxt = flag_r & ~wdata_i[3:0];
      end
      flag_nxt = flag_nxt | {hit.ofs, hit.ph, hit.dc, hit.pr};
      if (!ctrl_nxt[`PWMC_CTRL_EN] || !en) begin
         flag_nxt = 4'h0;
      end
      if (wr_i && addr_i == `PWMC_OFS_CTRL && mode != PWMC_MODE_STD) begin
         wav_nxt = wdata_i[`PWMC_CTRL_OUT];
      end else if (en) begin
         if (hit.ph) begin
            wav_nxt = 1'b1;
         end
         if (hit.dc) begin
            wav_nxt = 1'b0;
         end
      end else begin
         wav_nxt = 1'b0;
      end
      lvl     = wav_r ^ ctrl_r[`PWMC_CTRL_INV];
      pin_nxt = lvl;
      div_nxt   = 2'(div_r + 2'h1);
      out_s_nxt = (div_r == 2'(`PWMC_INSTR_DIV - 1)) ? wav_r : out_s_r;
      rdata_nxt = 16'h0000;
      if (rd_i) begin
         unique case (addr_i)
            `PWMC_OFS_CTRL:   rdata_nxt = {8'h00, ctrl_r[7:6], out_s_r, ctrl_r[4:0]};
            `PWMC_OFS_CLKSEL: rdata_nxt = {8'h00, clk_r};
            `PWMC_OFS_FLAG:   rdata_nxt = {12'h000, flag_r};
            `PWMC_OFS_MASK:   rdata_nxt = {12'h000, mask_r};
            `PWMC_OFS_PERIOD: rdata_nxt = evt_r.period;
            `PWMC_OFS_DUTY:   rdata_nxt = evt_r.duty;
            `PWMC_OFS_PHASE:  rdata_nxt = evt_r.phase;
            `PWMC_OFS_OFFSET: rdata_nxt = evt_r.offset;
            `PWMC_OFS_COUNT:  rdata_nxt = 16'(cnt_r);
            default:          rdata_nxt = 16'h0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         ctrl_r  <= `PWMC_CTRL_RST;
         clk_r   <= `PWMC_CLK_RST;
         flag_r  <= 4'(`PWMC_FLAG_RST);
         mask_r  <= 4'h0;
         evt_r   <= '0;
         cnt_r   <= '0;
         wav_r   <= 1'b0;
         pin_r   <= 1'b0;
         div_r   <= 2'h0;
         out_s_r <= 1'b0;
         rdata_r <= 16'h0000;
      end else if (ce_i) begin
         ctrl_r  <= ctrl_nxt;
         clk_r   <= clk_nxt;
         flag_r  <= flag_nxt;
         mask_r  <= mask_nxt;
         evt_r   <= evt_nxt;
         cnt_r   <= cnt_nxt;
         wav_r   <= wav_nxt;
         pin_r   <= pin_nxt;
         div_r   <= div_nxt;
         out_s_r <= out_s_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign rdata_o    = rdata_r;
   assign irq_o      = |(flag_r & mask_r);
   assign pwm_o      = open_drain_bit_i ? 1'b0 : pin_r;
   assign pwm_oe_n_o = open_drain_bit_i ? pin_r : 1'b0;
endmodule : pwmc_core
`default_nettype wire

/* File: verification/pwmc_core_assertions.sv */
// port checker for one pwm channel
`default_nettype none
`include "pwmc_defines.svh"
module pwmc_core_chk
   import pwmc_pkg::*;
#(
   parameter int CH_ID = 0,
   parameter int NCH   = 4
) (
   input wire logic        mclk_i,
   input wire logic        sys_rst_i,
   input wire logic        ce_i,
   input wire logic [3:0]  addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic        open_drain_bit_i,
   input wire logic        pwm_o,
   input wire logic        pwm_oe_n_o,
   input wire logic        irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       en_r;
   logic       inv_r;
   logic [3:0] mask_r;
   // shadow of enable, invert and mask
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         {en_r, inv_r, mask_r} <= '0;
      end else if (wr_i && ce_i) begin
         if (addr_i == `PWMC_OFS_CTRL) begin
            {en_r, inv_r} <= {wdata_i[7], wdata_i[4]};
         end
         if (addr_i == `PWMC_OFS_MIRROR) begin
            en_r <= wdata_i[CH_ID % NCH];
         end
         if (addr_i == `PWMC_OFS_MASK) begin
            mask_r <= wdata_i[3:0];
         end
      end
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   a_flag_upper_zero: assert property (
      rd_i && addr_i == `PWMC_OFS_FLAG |=> rdata_o[15:4] == 0) else $error("flag high bits");
   a_idle_pin_push: assert property (
      (!en_r && !open_drain_bit_i && $stable(inv_r))[*4] |-> pwm_o == inv_r && !pwm_oe_n_o)
      else $error("idle pin level");
   a_idle_pin_drain: assert property (
      (!en_r && open_drain_bit_i && $stable(inv_r))[*4] |-> !pwm_o && pwm_oe_n_o == inv_r)
      else $error("idle drain level");
   a_drain_low_only: assert property (
      open_drain_bit_i[*3] |-> !pwm_o) else $error("drain drives high");
   a_off_no_irq: assert property (
      (!en_r)[*2] |-> !irq_o) else $error("irq while disabled");
   a_off_flags_zero: assert property (
      rd_i && addr_i == `PWMC_OFS_FLAG && !en_r |=> rdata_o == 0) else $error("flags off");
   a_clksel_unused: assert property (
      rd_i && addr_i == `PWMC_OFS_CLKSEL |=> rdata_o[15:7] == 0 && rdata_o[3:2] == 0)
      else $error("clksel unused bits");
   a_mask_irq: assert property (
      (mask_r == 0)[*2] |-> !irq_o) else $error("irq while masked");
endmodule : pwmc_core_chk
bind pwmc_core pwmc_core_chk #(.CH_ID(CH_ID), .NCH(NCH)) u_chk (.mclk_i(mclk_i),
   .sys_rst_i(sys_rst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .open_drain_bit_i(open_drain_bit_i), .pwm_o(pwm_o),
   .pwm_oe_n_o(pwm_oe_n_o), .irq_o(irq_o));
`default_nettype wire

/* File: verification/pwmc_pin_load.sv */
// external load on the pwm pin with pull-up
`default_nettype none
module pwmc_pin_load (
   input  wire logic mclk_i,
   input  wire logic pwm_i,
   input  wire logic oe_n_i,
   input  wire logic pin_direction_bit_i,
   input  wire logic slew_limit_bit_i,
   output logic      level_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic wire_lvl;
   logic slow_r;
   // input or released pin floats high
   assign wire_lvl = (pin_direction_bit_i || oe_n_i) ? 1'b1 : pwm_i;
   always_ff @(posedge mclk_i) slow_r <= wire_lvl;
   assign level_o = slew_limit_bit_i ? slow_r : wire_lvl;
endmodule : pwmc_pin_load
`default_nettype wire

/* File: verification/pwm_core_output_and_flags_test.sv */
// self-checking bench for one pwm channel
`default_nettype none
module pwm_core_output_and_flags_test
   import pwmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk_i = 0;
   logic        sys_rst_i = 1;
   logic        wr_i = 0;
   logic        rd_i = 0;
   logic        hfo_i = 0;
   logic        lfo_i = 0;
   logic        od = 0;
   logic        rd_d = 0;
   logic [3:0]  addr_i = 0;
   logic [15:0] wdata_i = 0;
   logic [15:0] rdata_o;
   logic        pwm_o, pwm_oe_n_o, irq_o, level;
   logic [31:0] lfsr = 32'hA2F4;
   logic [15:0] exp_q[$];
   int          failures = 0;
   int          n_checks = 0;
   pwmc_core DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .hfo_i(hfo_i),
      .lfo_i(lfo_i), .open_drain_bit_i(od), .pwm_o(pwm_o), .pwm_oe_n_o(pwm_oe_n_o),
      .irq_o(irq_o));
   // pin set as output, fast edges
   pwmc_pin_load u_load (.mclk_i(mclk_i), .pwm_i(pwm_o), .oe_n_i(pwm_oe_n_o),
      .pin_direction_bit_i(1'b0), .slew_limit_bit_i(1'b0), .level_o(level));
   initial begin
      forever #5 mclk_i = ~mclk_i;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   always @(posedge mclk_i) begin
      hfo_i <= ~hfo_i;
      lfo_i <= lfsr[7];
      lfsr  <= lfsr_next(lfsr);
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // read result monitor
   always @(posedge mclk_i) begin
      if (rd_d) chk(rdata_o, exp_q.pop_front());
      rd_d <= rd_i;
   end
   // one bus cycle, read notes expected data
   task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      wr_i <= w;
      rd_i <= !w;
      addr_i <= a;
      wdata_i <= d;
      if (!w) exp_q.push_back(d);
      @(posedge mclk_i);
      wr_i <= 0;
      rd_i <= 0;
   endtask : acc
   task automatic pin(input logic [2:0] e);
      repeat (6) @(posedge mclk_i);
      @(negedge mclk_i);
      chk({13'h0, pwm_o, pwm_oe_n_o, level}, {13'h0, e});
   endtask : pin
   task automatic irq(input logic e);
      repeat (2) @(negedge mclk_i);
      chk({15'h0, irq_o}, {15'h0, e});
   endtask : irq
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (20000) @(posedge mclk_i);
      failures++;
      conclude();
   end
   initial begin
      logic [15:0] d;
      repeat (12) @(posedge mclk_i);
      sys_rst_i <= 0;
      for (int a = 0; a < 4; a++) acc(0, a[3:0], 16'h0000);
      acc(0, 4'hF, 16'h0000);
      for (int i = 4; i < 8; i++) begin
         d = lfsr[15:0];
         acc(1, i[3:0], d);
         acc(0, i[3:0], d);
      end
      acc(1, 4'h1, 16'hFFFF);
      acc(0, 4'h1, 16'h0073);
      for (int i = 0; i < 8; i++) begin
         d = 16'((i << 4) | (i % 4));
         acc(1, 4'h1, d);
         acc(0, 4'h1, d);
      end
      $display("test registers done");
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk_i);
         od <= i[1];
         acc(1, 4'h0, {11'h0, i[0], 4'h0});
         pin({~i[1] & i[0], i[1] & i[0], i[0]});
      end
      @(posedge mclk_i);
      od <= 0;
      acc(1, 4'h1, 16'h0003);
      // force obeys the mode already held, so load the mode first
      acc(1, 4'h0, 16'h0084);
      acc(1, 4'h0, 16'h00A4);
      pin(3'b101);
      acc(0, 4'h0, 16'h00A4);
      acc(1, 4'h0, 16'h0084);
      pin(3'b000);
      acc(0, 4'h0, 16'h0084);
      $display("test pin done");
      acc(1, 4'h0, 16'h0000);
      acc(1, 4'h4, 16'h0008);
      acc(1, 4'h5, 16'h0004);
      acc(1, 4'h6, 16'h0001);
      acc(1, 4'h7, 16'h0002);
      acc(1, 4'h1, 16'h0071);
      acc(1, 4'h9, 16'h0001);
      acc(0, 4'h0, 16'h0080);
      repeat (2600) @(posedge mclk_i);
      acc(0, 4'h2, 16'h000F);
      irq(1'b0);
      acc(1, 4'h3, 16'h0001);
      irq(1'b1);
      acc(1, 4'h2, 16'h0001);
      acc(0, 4'h2, 16'h000E);
      irq(1'b0);
      acc(1, 4'h3, 16'h0008);
      irq(1'b1);
      acc(1, 4'h0, 16'h0000);
      acc(0, 4'h2, 16'h0000);
      irq(1'b0);
      acc(0, 4'h8, 16'h0000);
      $display("test flags done");
      conclude();
   end
endmodule : pwm_core_output_and_flags_test
`default_nettype wire
